// ==== shared/tac_pkg.sv ====
// Constants, field layout and types for the throttle alert configuration block.
// Assumes a 100 MHz core clock; cycle counts are derived from that rate.
`default_nettype none
package tac_pkg;

    // Register command code, width and power-on value
    localparam logic [7:0] TAC_CMD_OPTION_A = 8'h33;
    localparam int TAC_REG_W = 16;
    localparam logic [15:0] TAC_OPTION_A_RST = 16'h4A54;

    // Field layout of throttle_alert_option_a, MSB first
    typedef struct packed {
        logic [4:0] overload_level2_threshold;  // 15:11
        logic [1:0] critical_current_deglitch;  // 10:9
        logic resv8;                            // 8
        logic [1:0] system_voltage_threshold;   // 7:6
        logic alert_extend_enable;              // 5
        logic [1:0] alert_min_width;            // 4:3
        logic alert_clear;                      // 2
        logic nominal_current_deglitch;         // 1
        logic resv0;                            // 0
    } tac_opt_t;

    // Clock rate and times in their own units
    localparam int TAC_CLK_MHZ = 100;
    localparam int TAC_CRIT_DEG0_US = 15;
    localparam int TAC_CRIT_DEG1_US = 100;
    localparam int TAC_CRIT_DEG2_US = 400;
    localparam int TAC_CRIT_DEG3_US = 800;
    localparam int TAC_SYS_DEG_US = 20;
    localparam int TAC_NOM_DEG0_MS = 1;
    localparam int TAC_NOM_DEG1_MS = 50;
    localparam int TAC_WIDTH0_US = 100;
    localparam int TAC_WIDTH1_MS = 1;
    localparam int TAC_WIDTH2_MS = 10;
    localparam int TAC_WIDTH3_MS = 5;

    // Derived cycle counts
    localparam int TAC_CRIT_DEG0_CYC = TAC_CRIT_DEG0_US * TAC_CLK_MHZ;
    localparam int TAC_CRIT_DEG1_CYC = TAC_CRIT_DEG1_US * TAC_CLK_MHZ;
    localparam int TAC_CRIT_DEG2_CYC = TAC_CRIT_DEG2_US * TAC_CLK_MHZ;
    localparam int TAC_CRIT_DEG3_CYC = TAC_CRIT_DEG3_US * TAC_CLK_MHZ;
    localparam int TAC_SYS_DEG_CYC = TAC_SYS_DEG_US * TAC_CLK_MHZ;
    localparam int TAC_NOM_DEG0_CYC = TAC_NOM_DEG0_MS * 1000 * TAC_CLK_MHZ;
    localparam int TAC_NOM_DEG1_CYC = TAC_NOM_DEG1_MS * 1000 * TAC_CLK_MHZ;
    localparam int TAC_WIDTH0_CYC = TAC_WIDTH0_US * TAC_CLK_MHZ;
    localparam int TAC_WIDTH1_CYC = TAC_WIDTH1_MS * 1000 * TAC_CLK_MHZ;
    localparam int TAC_WIDTH2_CYC = TAC_WIDTH2_MS * 1000 * TAC_CLK_MHZ;
    localparam int TAC_WIDTH3_CYC = TAC_WIDTH3_MS * 1000 * TAC_CLK_MHZ;

    // Overload level-2 code map: percent = base + step * (code - first)
    localparam logic [4:0] TAC_L2_FINE_FIRST = 5'h01;
    localparam logic [4:0] TAC_L2_FINE_LAST = 5'h19;
    localparam logic [4:0] TAC_L2_COARSE_FIRST = 5'h1A;
    localparam logic [4:0] TAC_L2_OFF = 5'h1F;
    localparam logic [9:0] TAC_L2_FINE_BASE = 10'd110;
    localparam logic [9:0] TAC_L2_FINE_STEP = 10'd5;
    localparam logic [9:0] TAC_L2_COARSE_BASE = 10'd250;
    localparam logic [9:0] TAC_L2_COARSE_STEP = 10'd50;

    // Critical trip is 110 % of level-2; nominal is 110 % of the limit
    localparam logic [7:0] TAC_TRIP_NUM = 8'd11;
    localparam logic [7:0] TAC_TRIP_DEN = 8'd10;
    localparam logic [9:0] TAC_PCT_SCALE = 10'd100;

    // System rail floors in millivolts, by code, for 2-4 cells and 1 cell
    localparam logic [15:0] TAC_SYSTEM_RAIL_VOLTAGE_MULTI_MV [4] = '{16'd5750, 16'd6000, 16'd6250, 16'd6500};
    localparam logic [15:0] TAC_SYSTEM_RAIL_VOLTAGE_ONE_MV [4] = '{16'd2850, 16'd3100, 16'd3350, 16'd3600};

endpackage

`default_nettype wire

// ==== core/tac_core.sv ====
// Throttle alert configuration and timing: one option register, three
// deglitched trigger conditions and the active-low alert output.
// Assumes current and voltage words come from converters on the core clock.
//
// Overview of operation
// - Option register answers at command 33h, resets to 4A54h.
// - Bits 15:11 hold level-2 threshold, reset 01001b (150 percent).
// - Codes 1 to 25 give 110 to 230 percent, 5 percent steps.
// - Codes 26 to 30 give 250 to 450 percent, 50 percent steps.
// - Code 31 disables the critical comparison entirely.
// - Critical trip is 110 percent of level-2; above it alerts.
// - Bits 10:9 pick critical deglitch 15, 100, 400 or 800 us.
// - 400 us stays under 500 us; 800 us stays under 1 ms.
// - Rail below selected floor for 20 us triggers the alert.
// - Bits 7:6 pick floor by cell count; reset code 01b.
// - With bit 5 set, alert holds low until bit 2 written 0.
// - Without extension, alert stays low at least bits 4:3 width.
// - Writing clear bit 0 releases an extended alert; 1 is idle.
// - Nominal trip is current above 110 percent of input limit.
// - Bit 1 picks nominal deglitch 1 ms or 50 ms.
`timescale 1ns/1ps
`default_nettype none

module tac_core
    import tac_pkg::*;
#(
    parameter int CRIT_DEG1_CYC = tac_pkg::TAC_CRIT_DEG1_CYC,
    parameter int CRIT_DEG2_CYC = tac_pkg::TAC_CRIT_DEG2_CYC,
    parameter int CRIT_DEG3_CYC = tac_pkg::TAC_CRIT_DEG3_CYC,
    parameter int NOM_DEG0_CYC = tac_pkg::TAC_NOM_DEG0_CYC,
    parameter int NOM_DEG1_CYC = tac_pkg::TAC_NOM_DEG1_CYC,
    parameter int WIDTH1_CYC = tac_pkg::TAC_WIDTH1_CYC,
    parameter int WIDTH2_CYC = tac_pkg::TAC_WIDTH2_CYC,
    parameter int WIDTH3_CYC = tac_pkg::TAC_WIDTH3_CYC,
    parameter int WIDTH0_CYC = tac_pkg::TAC_WIDTH0_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [7:0] i_cmd,
    input wire logic i_wr_en,
    input wire logic [15:0] i_wr_data,
    input wire logic [15:0] i_input_current,
    input wire logic [15:0] i_input_current_limit,
    input wire logic [15:0] i_system_rail_mv,
    input wire logic i_one_cell,
    output logic [15:0] o_rd_data,
    output logic o_throttle_alert_n
);
    import tac_pkg::*;

    tac_opt_t opt_q;
    logic [15:0] rd_data_q;
    logic alert_n_q;
    logic wr_hit;
    logic [9:0] l2_pct;
    logic l2_valid;
    logic crit_raw, nom_raw, sys_raw;
    logic crit_fire, nom_fire, sys_fire;
    logic any_fire;
    logic [31:0] crit_cnt_q, nom_cnt_q, sys_cnt_q, width_cnt_q;
    logic [31:0] crit_lim, nom_lim, width_lim;
    logic hold_q;
    logic [15:0] sys_floor;

    // Advance a deglitch counter; any drop of the condition restarts it
    function automatic logic [31:0] deg_next(input logic cond, input logic [31:0] cnt,
                                             input logic [31:0] lim);
        logic [31:0] r;
        r = 32'h0;
        if (cond) begin
            r = (cnt < lim) ? cnt + 32'h1 : cnt;
        end
        return r;
    endfunction

    assign wr_hit = i_wr_en && (i_cmd == TAC_CMD_OPTION_A);

    always_comb begin
        l2_valid = 1'b1;
        l2_pct = 10'h0;
        if (opt_q.overload_level2_threshold >= TAC_L2_FINE_FIRST &&
            opt_q.overload_level2_threshold <= TAC_L2_FINE_LAST) begin
            l2_pct = TAC_L2_FINE_BASE + TAC_L2_FINE_STEP *
                     10'(opt_q.overload_level2_threshold - TAC_L2_FINE_FIRST);
        end else if (opt_q.overload_level2_threshold >= TAC_L2_COARSE_FIRST &&
                     opt_q.overload_level2_threshold != TAC_L2_OFF) begin
            l2_pct = TAC_L2_COARSE_BASE + TAC_L2_COARSE_STEP *
                     10'(opt_q.overload_level2_threshold - TAC_L2_COARSE_FIRST);
        end else begin
            l2_valid = 1'b0;  // Code 0 is unlisted, treated as off too
        end
    end

    // critical compare, 110 % of level-2
    // Scaled to integers: cur*100*10 > lim*pct*11, kept in 40 bits
    assign crit_raw = l2_valid &&
        (40'(i_input_current) * 40'(TAC_PCT_SCALE) * 40'(TAC_TRIP_DEN) >
         40'(i_input_current_limit) * 40'(l2_pct) * 40'(TAC_TRIP_NUM));

    // nominal compare, 10 % over limit
    assign nom_raw = (20'(i_input_current) * 20'(TAC_TRIP_DEN) >
                      20'(i_input_current_limit) * 20'(TAC_TRIP_NUM));

    assign sys_floor = i_one_cell ? TAC_SYSTEM_RAIL_VOLTAGE_ONE_MV[opt_q.system_voltage_threshold]
                                  : TAC_SYSTEM_RAIL_VOLTAGE_MULTI_MV[opt_q.system_voltage_threshold];
    assign sys_raw = (i_system_rail_mv < sys_floor);

    // typical figures sit well inside the maximums
    always_comb begin
        case (opt_q.critical_current_deglitch)
            2'b00: crit_lim = 32'(TAC_CRIT_DEG0_CYC);
            2'b01: crit_lim = 32'(CRIT_DEG1_CYC);
            2'b10: crit_lim = 32'(CRIT_DEG2_CYC);
            default: crit_lim = 32'(CRIT_DEG3_CYC);
        endcase
    end

    assign nom_lim = opt_q.nominal_current_deglitch ? 32'(NOM_DEG1_CYC) : 32'(NOM_DEG0_CYC);

    always_comb begin
        case (opt_q.alert_min_width)
            2'b00: width_lim = 32'(WIDTH0_CYC);
            2'b01: width_lim = 32'(WIDTH1_CYC);
            2'b10: width_lim = 32'(WIDTH2_CYC);
            default: width_lim = 32'(WIDTH3_CYC);
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            crit_cnt_q <= 32'h0;
            nom_cnt_q <= 32'h0;
            sys_cnt_q <= 32'h0;
        end else if (i_ce) begin
            crit_cnt_q <= deg_next(crit_raw, crit_cnt_q, crit_lim);
            nom_cnt_q <= deg_next(nom_raw, nom_cnt_q, nom_lim);
            sys_cnt_q <= deg_next(sys_raw, sys_cnt_q, 32'(TAC_SYS_DEG_CYC));
        end
    end

    // A condition fires once it has held for its full deglitch count
    assign crit_fire = crit_raw && (crit_cnt_q >= crit_lim);
    assign nom_fire = nom_raw && (nom_cnt_q >= nom_lim);
    assign sys_fire = sys_raw && (sys_cnt_q >= 32'(TAC_SYS_DEG_CYC));
    assign any_fire = crit_fire || nom_fire || sys_fire;

    // threshold field reset via reset word
    // clear returns to idle once the hold is dropped
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            opt_q <= tac_opt_t'(TAC_OPTION_A_RST);
        end else if (i_ce) begin
            if (wr_hit) begin
                opt_q <= tac_opt_t'(i_wr_data);
            end else if (!opt_q.alert_clear && !hold_q) begin
                opt_q.alert_clear <= 1'b1;  // Self-return so the next pulse can latch
            end
        end
    end

    // host clear releases; a new trigger wins over the clear
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_q <= 1'b0;
        end else if (i_ce) begin
            if (opt_q.alert_extend_enable && any_fire) begin
                hold_q <= 1'b1;
            end else if (!opt_q.alert_extend_enable || !opt_q.alert_clear) begin
                hold_q <= 1'b0;
            end
        end
    end

    // width counter reloads while a trigger stands
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            width_cnt_q <= 32'h0;
        end else if (i_ce) begin
            if (any_fire) begin
                width_cnt_q <= width_lim;
            end else if (width_cnt_q != 32'h0) begin
                width_cnt_q <= width_cnt_q - 32'h1;
            end
        end
    end

    // alert pin drive, low while any source holds it
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            alert_n_q <= 1'b1;
        end else if (i_ce) begin
            if (opt_q.alert_extend_enable) begin
                alert_n_q <= !(any_fire || hold_q);
            end else begin
                alert_n_q <= !(any_fire || width_cnt_q > 32'h1);
            end
        end
    end

    // Read port: registered, zero for any other command
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_data_q <= 16'h0;
        end else if (i_ce) begin
            rd_data_q <= (i_cmd == TAC_CMD_OPTION_A) ? 16'(opt_q) : 16'h0;
        end
    end

    assign o_rd_data = rd_data_q;
    assign o_throttle_alert_n = alert_n_q;

endmodule

`default_nettype wire

// ==== test/tac_host_model.sv ====
// Host model: writes and reads the option register.
// Assumes one caller at a time, driving at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tac_host_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_rd_data,
    output logic [7:0] o_cmd,
    output logic o_wr_en,
    output logic [15:0] o_wr_data
);
    // Idle on the option command
    initial begin
        o_cmd = 8'h33;
        o_wr_en = 1'b0;
        o_wr_data = 16'h0000;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge i_mclk);
        o_cmd = c;
        o_wr_data = d;
        o_wr_en = 1'b1;
        @(negedge i_mclk);
        o_wr_en = 1'b0;
        o_cmd = 8'h33;
        o_wr_data = ~d; // No stale data left
    endtask
    // Answer lands one edge after the command
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge i_mclk);
        o_cmd = c;
        @(negedge i_mclk);
        d = i_rd_data;
    endtask
endmodule
`default_nettype wire

// ==== test/tac_monitor.sv ====
// Port checker for the throttle alert core.
// Assumes one clock and writes that land at the taking edge.
`timescale 1ns/1ps
`default_nettype none
module tac_monitor #(
    parameter int NOM_DEG0_CYC = 100,
    parameter int WIDTH0_CYC = 100,
    parameter int WIDTH1_CYC = 100,
    parameter int WIDTH2_CYC = 100,
    parameter int WIDTH3_CYC = 100
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [7:0] i_cmd,
    input wire logic i_wr_en,
    input wire logic [15:0] i_wr_data,
    input wire logic [15:0] i_input_current,
    input wire logic [15:0] i_input_current_limit,
    input wire logic [15:0] i_system_rail_mv,
    input wire logic i_one_cell,
    input wire logic [15:0] o_rd_data,
    input wire logic o_throttle_alert_n
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    logic [15:0] sh_q;
    int nr_q, lc_q, wsel;
    logic wr33, nom;
    assign wr33 = i_ce && i_wr_en && i_cmd == 8'h33;
    assign nom = i_input_current * 32'd10 > i_input_current_limit * 32'd11;
    assign wsel = sh_q[4] ? (sh_q[3] ? WIDTH3_CYC : WIDTH2_CYC) : (sh_q[3] ? WIDTH1_CYC : WIDTH0_CYC);
    // Shadow register, nominal run and low time
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sh_q <= 16'h4A54;
            nr_q <= 0;
            lc_q <= 0;
        end else if (i_ce) begin
            sh_q <= wr33 ? i_wr_data : sh_q;
            nr_q <= nom ? nr_q + 1 : 0;
            lc_q <= o_throttle_alert_n ? 0 : lc_q + 1;
        end
    end
    chk_rd_shadow:
    assert property (i_ce && i_cmd == 8'h33 |=> (o_rd_data & 16'hFFFB) == ($past(sh_q) & 16'hFFFB))
        else $error("read data off");
    chk_rd_other:
    assert property (i_ce && i_cmd != 8'h33 |=> o_rd_data == 16'h0000) else $error("foreign read");
    chk_clear_idle:
    assert property (i_ce && i_cmd == 8'h33 && !sh_q[5] && !wr33 && !$past(wr33) && !$past(wr33, 2)
        |=> o_rd_data[2]) else $error("clear bit stuck");
    chk_rst_alert:
    assert property ($rose(i_arst_n) |-> o_throttle_alert_n) else $error("alert after reset");
    chk_nom_delay:
    assert property (nr_q == NOM_DEG0_CYC + 1 && !sh_q[1] |-> ##[0:2] !o_throttle_alert_n)
        else $error("nominal alert late");
    chk_width_min:
    assert property ($rose(o_throttle_alert_n) && !sh_q[5] |-> lc_q >= wsel - 2) else $error("short");
    chk_ext_hold:
    assert property ((sh_q[5] && !wr33)[*3] ##0 !o_throttle_alert_n |=> !o_throttle_alert_n)
        else $error("hold lost");
    chk_ce_freeze:
    assert property (!i_ce |=> $stable(o_rd_data) && $stable(o_throttle_alert_n)) else $error("moved");
    cover property (!o_throttle_alert_n && sh_q[5]);
    cover property ($rose(o_throttle_alert_n) && !sh_q[5]);
    cover property (wr33 && !i_wr_data[2]);
endmodule
bind tac_core tac_monitor #(.NOM_DEG0_CYC(NOM_DEG0_CYC), .WIDTH0_CYC(WIDTH0_CYC),
    .WIDTH1_CYC(WIDTH1_CYC), .WIDTH2_CYC(WIDTH2_CYC), .WIDTH3_CYC(WIDTH3_CYC)) u_mon (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_cmd(i_cmd), .i_wr_en(i_wr_en),
    .i_wr_data(i_wr_data), .i_input_current(i_input_current),
    .i_input_current_limit(i_input_current_limit), .i_system_rail_mv(i_system_rail_mv),
    .i_one_cell(i_one_cell), .o_rd_data(o_rd_data), .o_throttle_alert_n(o_throttle_alert_n));
`default_nettype wire

// ==== test/throttle_alert_config_bench.sv ====
// Bench for the throttle alert core with a host model.
// Assumes 100 MHz and shortened deglitch and width counts.
`timescale 1ns/1ps
`default_nettype none
module throttle_alert_config_bench;
    logic i_mclk, i_arst_n, i_ce, i_one_cell, wr, alert_n;
    logic [7:0] cmd;
    logic [15:0] wd, cur, lim, rail, rd, rdo, d;
    logic [31:0] seed;
    int n_mismatch, total_checks;
    int q[$];
    // Shortened counts keep the run short; critical 15 us and rail 20 us stay fixed
    localparam int CRIT1_CYC = 40;
    localparam int CRIT2_CYC = 60;
    localparam int CRIT3_CYC = 80;
    localparam int NOM0_CYC = 100;
    localparam int NOM1_CYC = 5000;
    localparam int WID0_CYC = 30;
    localparam int WID1_CYC = 40;
    localparam int WID2_CYC = 50;
    localparam int WID3_CYC = 60;
    int crit[4] = '{1500, CRIT1_CYC, CRIT2_CYC, CRIT3_CYC};
    int wid[4] = '{WID0_CYC, WID1_CYC, WID2_CYC, WID3_CYC};
    int nomd[2] = '{NOM0_CYC, NOM1_CYC};
    logic [4:0] cc[5] = '{5'h01, 5'h19, 5'h1A, 5'h1E, 5'h1F};
    tac_core #(.CRIT_DEG1_CYC(CRIT1_CYC), .CRIT_DEG2_CYC(CRIT2_CYC), .CRIT_DEG3_CYC(CRIT3_CYC),
        .NOM_DEG0_CYC(NOM0_CYC), .NOM_DEG1_CYC(NOM1_CYC), .WIDTH0_CYC(WID0_CYC),
        .WIDTH1_CYC(WID1_CYC), .WIDTH2_CYC(WID2_CYC), .WIDTH3_CYC(WID3_CYC))
        uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_cmd(cmd),
        .i_wr_en(wr), .i_wr_data(wd), .i_input_current(cur), .i_input_current_limit(lim),
        .i_system_rail_mv(rail), .i_one_cell(i_one_cell), .o_rd_data(rdo),
        .o_throttle_alert_n(alert_n));
    tac_host_model host (.i_mclk(i_mclk), .i_rd_data(rdo), .o_cmd(cmd), .o_wr_en(wr),
        .o_wr_data(wd));
    // Free-running clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int pct(input logic [4:0] c);
        return (c <= 5'h19) ? 110 + 5 * (int'(c) - 1) : 250 + 50 * (int'(c) - 26);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // Quiet for lim-1 edges, then low within a few
    task automatic trig(input int lim);
        int k;
        tick(lim - 1);
        chk(alert_n, 1'b1);
        for (k = 0; k < 5 && alert_n !== 1'b0; k++) tick(1);
        chk(alert_n, 1'b0);
    endtask
    // Bounded wait for release; width must have passed
    task automatic rel(input int w);
        int k;
        for (k = 0; k < w + 9 && alert_n !== 1'b1; k++) tick(1);
        chk(alert_n, 1'b1);
        chk(k >= w - 2, 1'b1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        {i_arst_n, i_one_cell, i_ce} = 3'h1;
        {cur, lim, rail} = {16'h0000, 16'h03E8, 16'h2EE0};
        {n_mismatch, total_checks, seed} = {32'h0, 32'h0, 32'hD1E4};
        tick(12);
        i_arst_n = 1'b1;
        host.rd(8'h33, rd);
        chk(rd, 16'h4A54);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            d = (seed[15:0] & 16'hFFDF) | 16'h0004;
            host.wr((i % 2) ? 8'h34 : 8'h33, d);
            if (i % 2 == 0) q.push_back(d);
            host.rd(8'h33, rd);
            chk(rd, q[$]);
        end
        host.rd(8'h34, rd);
        chk(rd, 0);
        i_ce = 1'b0;
        tick(3);
        i_ce = 1'b1;
        host.wr(8'h33, 16'h4A50);
        host.rd(8'h33, rd);
        chk(rd, 16'h4A54);
        for (int w = 0; w < 4; w++) begin
            host.wr(8'h33, 16'h4A44 | 16'(w * 8 + (w % 2) * 2));
            cur = 16'h044C;
            tick(nomd[w % 2] + 5);
            chk(alert_n, 1'b1);
            cur = 16'h044D;
            tick(nomd[w % 2] / 2);
            cur = 16'h0000;
            tick(1);
            cur = 16'h044D;
            trig(nomd[w % 2]);
            cur = 16'h0000;
            rel(wid[w]);
        end
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h33, {cc[i], 2'(i % 4), 9'h046});
            cur = 16'(pct(cc[i]) * 11);
            tick(crit[i % 4] + 5);
            chk(alert_n, 1'b1);
            cur = cur + 16'h0001;
            // Code 31 turns the critical compare off, so there is no pulse to release
            if (cc[i] == 5'h1F) begin
                tick(1600);
                chk(alert_n, 1'b1);
                cur = 16'h0000;
            end else begin
                trig(crit[i % 4]);
                cur = 16'h0000;
                rel(WID0_CYC);
            end
        end
        for (int s = 0; s < 8; s++) begin
            i_one_cell = 1'(s / 4);
            host.wr(8'h33, 16'h4A14 | 16'((s % 4) * 64));
            rail = 16'(((s / 4) ? 2850 : 5750) + 250 * (s % 4));
            tick(2005);
            chk(alert_n, 1'b1);
            rail = rail - 16'h0001;
            trig(2000);
            seed = xs(seed);
            rail = 16'h2000 | {4'h0, seed[11:0]};
            rel(50);
        end
        host.wr(8'h33, 16'h4A74);
        cur = 16'h044D;
        trig(100);
        cur = 16'h0000;
        tick(80);
        chk(alert_n, 1'b0);
        host.wr(8'h33, 16'h4A70);
        rel(1);
        host.rd(8'h33, rd);
        chk(rd, 16'h4A74);
        end_sim();
    end
endmodule
`default_nettype wire
